//--- core/vc0_resource_pkg.sv
// What this block does and what software must do
// [R1] snoop-rejection capability bit is read-only and reads 0: all snoop attributes accepted
// [R2] low fifteen capability bits read zero and are read-only
// [R3] default channel enable bit reads 1 and is read-only
// [R4] three-bit default channel identifier reads zero and is read-only
// [R5] class map bits 7:1 writable, one bit per class, reset to all ones
// [R6] class zero map bit is read-only and always reads 1
// [R7] software drains traffic of a class before removing it from the map
// [R8] negotiation pending reads 1 during init or disable, 0 when negotiation done
// [R9] pending is set on reset, channel disabled, or link down
// [R10] pending clears when the link successfully leaves the second flow-control init state
// [R11] software checks pending is clear at both link ends before using the channel
// [R12] writes to read-only and reserved bits are ignored; fixed values keep reading back
package vc0_resource_pkg;

  localparam int          CFG_ADDR_W       = 12;
  localparam int          CFG_DATA_W       = 32;
  localparam int          CFG_BE_W         = 4;
  localparam int          CLASS_COUNT      = 8;

  localparam logic [11:0] CAP_OFFSET       = 12'h110;
  localparam logic [11:0] CTL_OFFSET       = 12'h114;
  localparam logic [11:0] STS_OFFSET       = 12'h11a;

  localparam logic [31:0] CAP_RESET        = 32'h00000000;
  localparam logic [31:0] CTL_RESET        = 32'h800000ff;
  localparam logic [15:0] STS_RESET        = 16'h0002;

  localparam int          SNOOP_REJECT_BIT = 15;
  localparam int          CHAN_ENABLE_BIT  = 31;
  localparam int          CHAN_ID_LSB      = 24;
  localparam int          CHAN_ID_MSB      = 26;
  localparam int          MAP_LSB          = 1;
  localparam int          MAP_MSB          = 7;
  localparam int          PENDING_BIT      = 1;
  localparam int          STS_LANE_LSB     = 16;

  localparam logic        SNOOP_REJECT_VAL = 1'b0;
  localparam logic        CHAN_ENABLE_VAL  = 1'b1;
  localparam logic [2:0]  CHAN_ID_VAL      = 3'h0;
  localparam logic        CLASS_ZERO_VAL   = 1'b1;
  localparam logic [6:0]  MAP_RESET        = 7'h7f;
  localparam logic        PENDING_RESET    = 1'b1;

endpackage : vc0_resource_pkg

//--- core/link_status_if.sv
interface link_status_if;
  logic dlDown;
  logic fcInit2Exit;
  logic chanEnable;
  logic pending;

  modport tracker
  (
    input  dlDown,
    input  fcInit2Exit,
    input  chanEnable,
    output pending
  );

  modport bank
  (
    output dlDown,
    output fcInit2Exit,
    output chanEnable,
    input  pending
  );
endinterface : link_status_if

//--- core/negotiation_tracker.sv
module negotiation_tracker
(
  input wire logic          clk,
  input wire logic          reset_n,
  input wire logic          ce,
  link_status_if.tracker    lnk
);
  import vc0_resource_pkg::*;

  logic pendingReg;

  // set terms win over the exit event so a link drop in the exit cycle is never missed
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pendingReg <= PENDING_RESET; // R9
    else if (ce)
    begin
      if (lnk.dlDown || !lnk.chanEnable)
        pendingReg <= 1'b1; // R9
      else if (lnk.fcInit2Exit)
        pendingReg <= 1'b0; // R10
    end
  end

  assign lnk.pending = pendingReg; // R8

  property p_pending_on_down;
    @(posedge clk) disable iff (!reset_n)
    (ce && lnk.dlDown) |=> lnk.pending;
  endproperty
  a_pending_on_down: assert property (p_pending_on_down) // R9
    else $error("pending not set after link down");

  property p_pending_clear;
    @(posedge clk) disable iff (!reset_n)
    (ce && lnk.fcInit2Exit && !lnk.dlDown && lnk.chanEnable) |=> !lnk.pending;
  endproperty
  a_pending_clear: assert property (p_pending_clear) // R10
    else $error("pending not cleared after init exit");

  property p_pending_holds_low;
    @(posedge clk) disable iff (!reset_n)
    (!lnk.pending && !(ce && (lnk.dlDown || !lnk.chanEnable))) |=> !lnk.pending;
  endproperty
  a_pending_holds_low: assert property (p_pending_holds_low) // R8
    else $error("pending rose without a cause");

  property p_pending_holds_high;
    @(posedge clk) disable iff (!reset_n)
    (lnk.pending && !(ce && lnk.fcInit2Exit)) |=> lnk.pending;
  endproperty
  a_pending_holds_high: assert property (p_pending_holds_high) // R8
    else $error("pending fell without init exit");

  property p_cov_negotiate;
    @(posedge clk) disable iff (!reset_n)
    lnk.pending ##1 !lnk.pending ##[1:50] lnk.pending;
  endproperty
  c_negotiate: cover property (p_cov_negotiate);

endmodule : negotiation_tracker

//--- core/vc0_resource_regs.sv
module vc0_resource_regs
(
  input  wire logic                                   clk,
  input  wire logic                                   reset_n,
  input  wire logic                                   ce,
  input  wire logic [vc0_resource_pkg::CFG_ADDR_W-1:0] cfgAddr,
  input  wire logic                                   cfgWrEn,
  input  wire logic [vc0_resource_pkg::CFG_BE_W-1:0]   cfgByteEn,
  input  wire logic [vc0_resource_pkg::CFG_DATA_W-1:0] cfgWrData,
  input  wire logic                                   cfgRdEn,
  output      logic [vc0_resource_pkg::CFG_DATA_W-1:0] cfgRdData,
  output      logic                                   cfgRdValid,
  input  wire logic                                   dlDown,
  input  wire logic                                   fcInit2Exit,
  output      logic [vc0_resource_pkg::CLASS_COUNT-1:0] classMap,
  output      logic                                   negotiationPending
);
  import vc0_resource_pkg::*;

  logic [MAP_MSB:MAP_LSB] mapReg;
  logic [31:0]            capValue;
  logic [31:0]            ctlValue;
  logic [15:0]            stsValue;
  logic [31:0]            rdNext;
  logic [31:0]            rdDataReg;
  logic                   rdValidReg;
  logic [9:0]             rdWordReg;
  logic                   ctlHit;
  logic                   ctlWrite;

  link_status_if lnk ();

  assign lnk.dlDown      = dlDown;
  assign lnk.fcInit2Exit = fcInit2Exit;
  assign lnk.chanEnable  = CHAN_ENABLE_VAL; // R9

  negotiation_tracker u_tracker
  (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .lnk     (lnk)
  );

  // decode by dword; status sits in the upper half-word of its dword
  assign ctlHit   = (cfgAddr[11:2] == CTL_OFFSET[11:2]);
  assign ctlWrite = ce && cfgWrEn && ctlHit && cfgByteEn[0];

  // only byte lane 0 holds writable bits; all other lanes drop their data
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      mapReg <= MAP_RESET; // R5
    else if (ctlWrite)
      mapReg <= cfgWrData[MAP_MSB:MAP_LSB]; // R5
  end

  always_comb
  begin
    capValue                   = CAP_RESET; // R2
    capValue[SNOOP_REJECT_BIT] = SNOOP_REJECT_VAL; // R1
  end

  always_comb
  begin
    ctlValue                          = 32'h00000000;
    ctlValue[CHAN_ENABLE_BIT]         = CHAN_ENABLE_VAL; // R3
    ctlValue[CHAN_ID_MSB:CHAN_ID_LSB] = CHAN_ID_VAL; // R4
    ctlValue[MAP_MSB:MAP_LSB]         = mapReg; // R5
    ctlValue[0]                       = CLASS_ZERO_VAL; // R6
  end

  always_comb
  begin
    stsValue              = 16'h0000;
    stsValue[PENDING_BIT] = lnk.pending; // R8
  end

  // fixed fields come from constants, so no write path can reach them
  always_comb
  begin
    rdNext = 32'h00000000;
    if (cfgAddr[11:2] == CAP_OFFSET[11:2])
      rdNext = capValue; // R12
    else if (cfgAddr[11:2] == CTL_OFFSET[11:2])
      rdNext = ctlValue; // R12
    else if (cfgAddr[11:2] == STS_OFFSET[11:2])
      rdNext = {stsValue, 16'h0000}; // R12
    else
      rdNext = 32'h00000000;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rdDataReg <= 32'h00000000;
      rdWordReg <= 10'h000;
    end
    else if (ce && cfgRdEn)
    begin
      rdDataReg <= rdNext;
      rdWordReg <= cfgAddr[11:2];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdValidReg <= 1'b0;
    else if (ce)
      rdValidReg <= cfgRdEn;
  end

  assign cfgRdData          = rdDataReg;
  assign cfgRdValid         = rdValidReg;
  assign classMap           = {mapReg, CLASS_ZERO_VAL}; // R6
  assign negotiationPending = lnk.pending; // R8

  property p_cap_reads_zero;
    @(posedge clk) disable iff (!reset_n)
    (cfgRdValid && rdWordReg == CAP_OFFSET[11:2]) |-> (cfgRdData == 32'h00000000);
  endproperty
  a_cap_reads_zero: assert property (p_cap_reads_zero) // R1
    else $error("capability word not zero");

  property p_cap_low_zero;
    @(posedge clk) disable iff (!reset_n)
    (cfgRdValid && rdWordReg == CAP_OFFSET[11:2]) |-> (cfgRdData[14:0] == 15'h0000);
  endproperty
  a_cap_low_zero: assert property (p_cap_low_zero) // R2
    else $error("capability low bits not zero");

  property p_enable_one;
    @(posedge clk) disable iff (!reset_n)
    (cfgRdValid && rdWordReg == CTL_OFFSET[11:2]) |-> cfgRdData[CHAN_ENABLE_BIT];
  endproperty
  a_enable_one: assert property (p_enable_one) // R3
    else $error("channel enable reads zero");

  property p_id_zero;
    @(posedge clk) disable iff (!reset_n)
    (cfgRdValid && rdWordReg == CTL_OFFSET[11:2]) |->
      (cfgRdData[CHAN_ID_MSB:CHAN_ID_LSB] == 3'h0 && cfgRdData[30:27] == 4'h0);
  endproperty
  a_id_zero: assert property (p_id_zero) // R4
    else $error("channel id not zero");

  property p_map_write;
    @(posedge clk) disable iff (!reset_n)
    ctlWrite |=> (classMap[7:1] == $past(cfgWrData[7:1]));
  endproperty
  a_map_write: assert property (p_map_write) // R5
    else $error("class map write lost");

  property p_class_zero;
    @(posedge clk) disable iff (!reset_n)
    (cfgRdValid && rdWordReg == CTL_OFFSET[11:2]) |-> (cfgRdData[0] && classMap[0]);
  endproperty
  a_class_zero: assert property (p_class_zero) // R6
    else $error("class zero map bit cleared");

  property p_sts_read;
    @(posedge clk) disable iff (!reset_n)
    (ce && cfgRdEn && cfgAddr[11:2] == STS_OFFSET[11:2]) |=>
      (cfgRdValid && cfgRdData == {14'h0000, $past(negotiationPending), 17'h00000});
  endproperty
  a_sts_read: assert property (p_sts_read) // R8
    else $error("status read mismatch");

  property p_ro_ignored;
    @(posedge clk) disable iff (!reset_n)
    (ce && cfgWrEn && !ctlWrite) |=> $stable(classMap);
  endproperty
  a_ro_ignored: assert property (p_ro_ignored) // R12
    else $error("class map changed on foreign write");

  property p_cov_map_write;
    @(posedge clk) disable iff (!reset_n)
    ctlWrite ##1 (ce && cfgRdEn && ctlHit);
  endproperty
  c_map_write: cover property (p_cov_map_write);

  property p_cov_sts_clear;
    @(posedge clk) disable iff (!reset_n)
    cfgRdValid && rdWordReg == STS_OFFSET[11:2] && !cfgRdData[17];
  endproperty
  c_sts_clear: cover property (p_cov_sts_clear);

  property p_cov_ro_write;
    @(posedge clk) disable iff (!reset_n)
    ce && cfgWrEn && cfgAddr[11:2] == CAP_OFFSET[11:2];
  endproperty
  c_ro_write: cover property (p_cov_ro_write);

endmodule : vc0_resource_regs

//--- dv/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import vc0_resource_pkg::*;

  logic        clk;
  logic        reset_n;
  logic        ce;
  logic [11:0] cfgAddr;
  logic        cfgWrEn;
  logic [3:0]  cfgByteEn;
  logic [31:0] cfgWrData;
  logic        cfgRdEn;
  logic [31:0] cfgRdData;
  logic        cfgRdValid;
  logic        dlDown;
  logic        fcInit2Exit;
  logic [7:0]  classMap;
  logic        negotiationPending;
  int          mismatches;
  int          n_compared;

  `define CHECK(got, exp) \
    begin \
      n_compared++; \
      if ((got) !== (exp)) \
      begin \
        mismatches++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
      end \
    end

  vc0_resource_regs dut
  (
    .clk                (clk),
    .reset_n            (reset_n),
    .ce                 (ce),
    .cfgAddr            (cfgAddr),
    .cfgWrEn            (cfgWrEn),
    .cfgByteEn          (cfgByteEn),
    .cfgWrData          (cfgWrData),
    .cfgRdEn            (cfgRdEn),
    .cfgRdData          (cfgRdData),
    .cfgRdValid         (cfgRdValid),
    .dlDown             (dlDown),
    .fcInit2Exit        (fcInit2Exit),
    .classMap           (classMap),
    .negotiationPending (negotiationPending)
  );

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic conclude();
    if (mismatches == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  // one write dword, held for exactly one taking edge
  task automatic cfgWrite(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    #1;
    cfgAddr   = a;
    cfgWrData = d;
    cfgByteEn = be;
    cfgWrEn   = 1'b1;
    @(posedge clk);
    #1;
    cfgWrEn   = 1'b0;
  endtask : cfgWrite

  // answer is registered on the taking edge and checked 1 ns after it
  task automatic cfgRead(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    #1;
    cfgAddr = a;
    cfgRdEn = 1'b1;
    @(posedge clk);
    #1;
    cfgRdEn = 1'b0;
    `CHECK(cfgRdValid, 1'b1)
    `CHECK(cfgRdData, exp)
  endtask : cfgRead

  task automatic linkPulse(input logic down, input logic exitInit);
    @(posedge clk);
    #1;
    dlDown      = down;
    fcInit2Exit = exitInit;
    @(posedge clk);
    #1;
    dlDown      = 1'b0;
    fcInit2Exit = 1'b0;
  endtask : linkPulse

  initial
  begin
    #(2000 * 25);
    mismatches++;
    conclude();
  end

  initial
  begin
    mismatches  = 0;
    n_compared  = 0;
    reset_n     = 1'b0;
    ce          = 1'b1;
    cfgAddr     = 12'h000;
    cfgWrEn     = 1'b0;
    cfgByteEn   = 4'h0;
    cfgWrData   = 32'h00000000;
    cfgRdEn     = 1'b0;
    dlDown      = 1'b0;
    fcInit2Exit = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    reset_n = 1'b1;
    `CHECK(negotiationPending, 1'b1)
    `CHECK(classMap, 8'hff)
    cfgRead(12'h110, 32'h00000000);
    cfgRead(12'h114, 32'h800000ff);
    cfgRead(12'h11a, 32'h00020000);
    // clearing every bit must leave class zero and the fixed fields standing
    cfgWrite(12'h114, 32'h00000000, 4'hf);
    cfgRead(12'h114, 32'h80000001);
    `CHECK(classMap, 8'h01)
    for (int i = 1; i < 8; i++)
    begin
      cfgWrite(12'h114, 32'h00000001 << i, 4'h1);
      `CHECK(classMap, 8'h01 | (8'h01 << i))
    end
    cfgWrite(12'h114, 32'hffffffff, 4'hf);
    cfgRead(12'h114, 32'h800000ff);
    cfgWrite(12'h114, 32'h00000000, 4'he);
    cfgRead(12'h114, 32'h800000ff);
    cfgWrite(12'h110, 32'hffffffff, 4'hf);
    cfgRead(12'h110, 32'h00000000);
    cfgWrite(12'h118, 32'hffffffff, 4'hf);
    cfgRead(12'h118, 32'h00020000);
    cfgRead(12'h200, 32'h00000000);
    // a write offered while the clock enable is low is never taken
    ce = 1'b0;
    cfgWrite(12'h114, 32'h00000000, 4'hf);
    ce = 1'b1;
    `CHECK(classMap, 8'hff)
    // exit while the link is down loses to the down state
    linkPulse(1'b1, 1'b1);
    `CHECK(negotiationPending, 1'b1)
    linkPulse(1'b0, 1'b1);
    `CHECK(negotiationPending, 1'b0)
    repeat (3) @(posedge clk);
    #1;
    `CHECK(negotiationPending, 1'b0)
    // software sees pending clear before it uses the channel
    cfgRead(12'h11a, 32'h00000000);
    linkPulse(1'b1, 1'b0);
    `CHECK(negotiationPending, 1'b1)
    cfgRead(12'h11a, 32'h00020000);
    linkPulse(1'b0, 1'b1);
    `CHECK(negotiationPending, 1'b0)
    // asynchronous reset in mid-run restores every default
    cfgWrite(12'h114, 32'h00000000, 4'h1);
    #3;
    reset_n = 1'b0;
    #1;
    `CHECK(classMap, 8'hff)
    `CHECK(negotiationPending, 1'b1)
    repeat (6) @(posedge clk);
    #1;
    reset_n = 1'b1;
    cfgRead(12'h114, 32'h800000ff);
    conclude();
  end
endmodule : testbench
